// [core/epd_cmd_core.v]
// Command interpreter of the electrophoretic panel driver
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`include "epd_consts.vh"

// How it works
// - Deep sleep command only with check code a5
// - Only hardware reset leaves deep sleep
// - Data bytes stored, four pixels, MSB first
// - Polarity set: code is gray; clear: inverted
// - Data stop returns frame received flag, bit 7
// - Data stop with full frame starts refresh
// - Refresh bit 0: table or fixed common voltage
// - Busy low for whole refresh
// - Refresh drives frame through lookup waveforms
// - Chained sequence a5, or a7 adding sleep
// - Frame rate code and dynamic enable kept
// - Temperature read returns integer then quarters
// - Sensor select bit picks internal or external
// - Offset added in half and quarter degrees
// - Power on drops busy until sequence ends
module epd_cmd_core #(
  parameter PUP_CYC = `EPD_PUP_TIME_US * `EPD_CLK_MHZ,
  parameter PDN_CYC = `EPD_PDN_TIME_US * `EPD_CLK_MHZ
) (
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire        sclk_pin,
  input  wire        csb_n_pin,
  input  wire        dc_pin,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe_n,
  input  wire [9:0]  temp_int_raw,
  input  wire [9:0]  temp_ext_raw,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata_q,
  output reg         busy_n_q,
  output reg         irq_q,
  output reg         int_sensor_en_q,
  output reg  [2:0]  frame_rate_select_q,
  output reg         dyn_frame_rate_q,
  output reg         panel_power_q,
  output reg  [1:0]  src_level_q,
  output reg         src_strobe_q,
  output reg  [1:0]  vcom_level_q,
  output reg         vcom_dc_q
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam ST_IDLE    = 3'h0;
  localparam ST_PUP     = 3'h1;
  localparam ST_REFRESH = 3'h2;
  localparam ST_PDN     = 3'h3;
  localparam ST_SLEEP   = 3'h4;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [7:0]  frame_mem [0:`EPD_FRAME_BYTES-1]; // Frame memory, flops
  reg  [2:0]  state_q;         // Sequencer state
  reg  [7:0]  cmd_q;           // Most recent command byte
  reg  [1:0]  param_idx_q;     // Parameters seen since the command
  reg  [13:0] wr_addr_q;       // Image write pointer
  reg         frame_full_q;    // Whole frame received
  reg         common_voltage_mode_select_q; // 1 = fixed level
  reg         data_polarity_select_q;       // 1 = direct mapping
  reg         temp_sensor_select_q;         // 1 = external sensor
  reg  [4:0]  temperature_offset_q;         // Offset code
  reg         auto_q;          // Chained sequence running
  reg         auto_sleep_q;    // Chain ends in deep sleep
  reg  [23:0] timer_q;         // Power sequence timer
  reg  [13:0] rd_addr_q;       // Refresh byte pointer
  reg  [1:0]  pix_q;           // Pixel inside the byte
  reg  [1:0]  phase_q;         // Waveform phase
  reg  [2:0]  div_q;           // Pixel rate divider
  reg         tx_load_q;       // Load the read-back shifter
  reg  [7:0]  tx_byte_q;       // Byte to read back
  reg  [4:0]  irq_stat_q;      // Sticky event bits
  reg  [4:0]  irq_mask_q;      // Enables for the events
  reg  [4:0]  ev;              // Events this cycle
  wire        byte_valid;
  wire [7:0]  byte_data;
  wire        byte_dc;
  wire [9:0]  temp_raw;
  wire [9:0]  temp_adj;
  wire [9:0]  off_q4;
  wire [1:0]  code;
  wire [1:0]  gray;

  // ----------------------------------------------------------------
  // Serial link
  // ----------------------------------------------------------------
  epd_link_rx u_link (
    .clk_sys      (clk_sys),
    .sys_rst      (sys_rst),
    .sclk_pin     (sclk_pin),
    .csb_n_pin    (csb_n_pin),
    .dc_pin       (dc_pin),
    .sda_in       (sda_in),
    .tx_load      (tx_load_q),
    .tx_byte      (tx_byte_q),
    .tx_en        (cmd_q == `EPD_CMD_DATA_STOP || cmd_q == `EPD_CMD_TEMP_READ),
    .byte_valid_q (byte_valid),
    .byte_q       (byte_data),
    .byte_dc_q    (byte_dc),
    .sda_out_q    (sda_out),
    .sda_oe_n_q   (sda_oe_n)
  );

  // ----------------------------------------------------------------
  // Temperature: quarter-degree units, offset sign-extended
  // ----------------------------------------------------------------
  assign temp_raw = temp_sensor_select_q ? temp_ext_raw : temp_int_raw;
  // Half-degree steps are two quarters; bit 4 adds one quarter
  assign off_q4   = {{5{temperature_offset_q[3]}}, temperature_offset_q[3:0], 1'b0}
                    + {9'h000, temperature_offset_q[4]};
  assign temp_adj = temp_raw + off_q4;

  // ----------------------------------------------------------------
  // Pixel decode for the refresh scan
  // ----------------------------------------------------------------
  // First pixel sits in the top bit pair
  assign code = frame_mem[rd_addr_q][{~pix_q, 1'b0} +: 2];
  assign gray = data_polarity_select_q ? code : ~code;

  // Collect event pulses for the interrupt bits
  always @* begin
    ev = 5'h00;
    ev[`EPD_IRQ_REFRESH]  = state_q == ST_REFRESH && div_q == 3'h0 && pix_q == 2'h3 &&
                            rd_addr_q == `EPD_FRAME_BYTES - 14'h1 && phase_q == `EPD_LUT_PHASES;
    ev[`EPD_IRQ_POWER_ON] = state_q == ST_PUP && timer_q == 24'h000000;
    ev[`EPD_IRQ_FRAME]    = byte_valid && byte_dc && cmd_q == `EPD_CMD_DATA_START &&
                            !frame_full_q && wr_addr_q == `EPD_FRAME_BYTES - 14'h1;
    ev[`EPD_IRQ_SLEEP]    = (state_q == ST_PDN && auto_sleep_q && timer_q == 24'h000000) ||
                            (state_q == ST_IDLE && byte_valid && byte_dc &&
                             cmd_q == `EPD_CMD_DEEP_SLEEP && byte_data == `EPD_SLEEP_CHECK);
    ev[`EPD_IRQ_IGNORED]  = byte_valid && !byte_dc && state_q != ST_IDLE && state_q != ST_SLEEP;
  end

  // ----------------------------------------------------------------
  // Command decoder and sequencer
  // ----------------------------------------------------------------
  // Commands land only when idle; a busy or sleeping device drops them
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_q                      <= ST_IDLE;
      cmd_q                        <= 8'h00;
      param_idx_q                  <= 2'h0;
      wr_addr_q                    <= 14'h0000;
      frame_full_q                 <= 1'b0;
      common_voltage_mode_select_q <= 1'b0;
      data_polarity_select_q       <= `EPD_POL_RST;
      temp_sensor_select_q         <= 1'b0;
      temperature_offset_q         <= 5'h00;
      frame_rate_select_q          <= `EPD_RATE_RST;
      dyn_frame_rate_q             <= 1'b0;
      auto_q                       <= 1'b0;
      auto_sleep_q                 <= 1'b0;
      timer_q                      <= 24'h000000;
      tx_load_q                    <= 1'b0;
      tx_byte_q                    <= 8'h00;
      panel_power_q                <= 1'b0;
    end else begin
      tx_load_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (byte_valid && !byte_dc) begin
            // Command byte: remember it, reset parameter count
            cmd_q       <= byte_data;
            param_idx_q <= 2'h0;
            case (byte_data)
              `EPD_CMD_POWER_ON: begin
                state_q <= ST_PUP;
                timer_q <= PUP_CYC[23:0];
              end
              `EPD_CMD_POWER_OFF: begin
                state_q <= ST_PDN;
                timer_q <= PDN_CYC[23:0];
              end
              `EPD_CMD_DATA_START: begin
                wr_addr_q    <= 14'h0000;
                frame_full_q <= 1'b0;
              end
              `EPD_CMD_DATA_STOP: begin
                tx_byte_q <= {frame_full_q, 7'h00};
                tx_load_q <= 1'b1;
                if (frame_full_q) begin
                  state_q <= ST_REFRESH;
                end
              end
              `EPD_CMD_TEMP_READ: begin
                tx_byte_q <= temp_adj[9:2];
                tx_load_q <= 1'b1;
              end
              default: begin
                tx_byte_q <= 8'h00;
              end
            endcase
          end else if (byte_valid && byte_dc) begin
            // Parameter byte of the most recent command
            if (param_idx_q != 2'h3) begin
              param_idx_q <= param_idx_q + 2'h1;
            end
            case (cmd_q)
              `EPD_CMD_DEEP_SLEEP: begin
                // Any other check value leaves the state alone
                if (byte_data == `EPD_SLEEP_CHECK) begin
                  state_q       <= ST_SLEEP;
                  panel_power_q <= 1'b0;
                end
              end
              `EPD_CMD_DATA_START: begin
                if (!frame_full_q) begin
                  frame_mem[wr_addr_q] <= byte_data;
                  wr_addr_q            <= wr_addr_q + 14'h1;
                  if (wr_addr_q == `EPD_FRAME_BYTES - 14'h1) begin
                    frame_full_q <= 1'b1;
                  end
                end
              end
              `EPD_CMD_REFRESH: begin
                if (param_idx_q == 2'h0) begin
                  common_voltage_mode_select_q <= byte_data[`EPD_VCOM_BIT];
                  state_q                      <= ST_REFRESH;
                end
              end
              `EPD_CMD_AUTO_SEQ: begin
                if (param_idx_q == 2'h0 &&
                    (byte_data == `EPD_AUTO_PLAIN || byte_data == `EPD_AUTO_SLEEP)) begin
                  auto_q       <= 1'b1;
                  auto_sleep_q <= byte_data == `EPD_AUTO_SLEEP;
                  state_q      <= ST_PUP;
                  timer_q      <= PUP_CYC[23:0];
                end
              end
              `EPD_CMD_FRAME_RATE: begin
                frame_rate_select_q <= byte_data[2:0];
                dyn_frame_rate_q    <= byte_data[`EPD_DYN_BIT];
              end
              `EPD_CMD_TEMP_READ: begin
                // Second read byte: the quarter-degree pair on top
                if (param_idx_q == 2'h0) begin
                  tx_byte_q <= {temp_adj[1:0], 6'h00};
                  tx_load_q <= 1'b1;
                end
              end
              `EPD_CMD_TEMP_SEL: begin
                temp_sensor_select_q <= byte_data[`EPD_SEN_BIT];
                temperature_offset_q <= byte_data[4:0];
              end
              `EPD_CMD_POLARITY: begin
                data_polarity_select_q <= byte_data[`EPD_POL_BIT];
              end
              default: begin
                tx_byte_q <= 8'h00;
              end
            endcase
          end
        end
        ST_PUP: begin
          // Power ramp; busy stays low until the timer runs out
          if (timer_q == 24'h000000) begin
            panel_power_q <= 1'b1;
            state_q       <= auto_q ? ST_REFRESH : ST_IDLE;
          end else begin
            timer_q <= timer_q - 24'h000001;
          end
        end
        ST_REFRESH: begin
          if (ev[`EPD_IRQ_REFRESH]) begin
            state_q <= auto_q ? ST_PDN : ST_IDLE;
            timer_q <= PDN_CYC[23:0];
          end
        end
        ST_PDN: begin
          if (timer_q == 24'h000000) begin
            panel_power_q <= 1'b0;
            auto_q        <= 1'b0;
            state_q       <= auto_sleep_q ? ST_SLEEP : ST_IDLE;
          end else begin
            timer_q <= timer_q - 24'h000001;
          end
        end
        ST_SLEEP: begin
          // Nothing on the link wakes it; only sys_rst does
          state_q <= ST_SLEEP;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Refresh scan: every pixel once per waveform phase
  // ----------------------------------------------------------------
  // Fixed small waveform tables keep the scan honest without a loader
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rd_addr_q    <= 14'h0000;
      pix_q        <= 2'h0;
      phase_q      <= 2'h0;
      div_q        <= 3'h0;
      src_level_q  <= 2'h0;
      src_strobe_q <= 1'b0;
      vcom_level_q <= 2'h0;
      vcom_dc_q    <= 1'b0;
    end else begin
      src_strobe_q <= 1'b0;
      if (state_q != ST_REFRESH) begin
        rd_addr_q    <= 14'h0000;
        pix_q        <= 2'h0;
        phase_q      <= 2'h0;
        div_q        <= `EPD_PIX_DIV;
        vcom_level_q <= 2'h0;
      end else if (div_q != 3'h0) begin
        div_q <= div_q - 3'h1;
      end else begin
        div_q        <= `EPD_PIX_DIV;
        src_strobe_q <= 1'b1;
        src_level_q  <= gray ^ phase_q;
        vcom_dc_q    <= common_voltage_mode_select_q;
        // Table mode walks the phase; fixed mode holds one level
        vcom_level_q <= common_voltage_mode_select_q ? 2'h1 : phase_q;
        pix_q        <= pix_q + 2'h1;
        if (pix_q == 2'h3) begin
          if (rd_addr_q == `EPD_FRAME_BYTES - 14'h1) begin
            rd_addr_q <= 14'h0000;
            phase_q   <= phase_q + 2'h1;
          end else begin
            rd_addr_q <= rd_addr_q + 14'h1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Status pins
  // ----------------------------------------------------------------
  // Busy low in every active state and in deep sleep
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      busy_n_q        <= 1'b1;
      int_sensor_en_q <= 1'b1;
    end else begin
      busy_n_q        <= state_q == ST_IDLE;
      int_sensor_en_q <= ~temp_sensor_select_q;
    end
  end

  // ----------------------------------------------------------------
  // Software registers and interrupt
  // ----------------------------------------------------------------
  // Set beats the write-one clear in the same cycle
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_q  <= 5'h00;
      irq_mask_q  <= 5'h00;
      irq_q       <= 1'b0;
      reg_rdata_q <= 32'h00000000;
    end else begin
      if (reg_wr && reg_addr == `EPD_REG_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~reg_wdata[4:0]) | ev;
      end else begin
        irq_stat_q <= irq_stat_q | ev;
      end
      if (reg_wr && reg_addr == `EPD_REG_IRQ_MASK) begin
        irq_mask_q <= reg_wdata[4:0];
      end
      irq_q       <= |(irq_stat_q & irq_mask_q);
      reg_rdata_q <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `EPD_REG_STATUS:   reg_rdata_q <= {24'h000000, frame_full_q, panel_power_q,
                                             auto_q, busy_n_q, 1'b0, state_q};
          `EPD_REG_IRQ_STAT: reg_rdata_q <= {27'h0000000, irq_stat_q};
          `EPD_REG_IRQ_MASK: reg_rdata_q <= {27'h0000000, irq_mask_q};
          `EPD_REG_CONFIG:   reg_rdata_q <= {10'h000, temp_sensor_select_q, temperature_offset_q,
                                             data_polarity_select_q, common_voltage_mode_select_q,
                                             dyn_frame_rate_q, frame_rate_select_q, temp_adj};
          default:           reg_rdata_q <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// [shared/epd_consts.vh]
// Constants for the panel driver command interpreter
`ifndef EPD_CONSTS_VH
`define EPD_CONSTS_VH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define EPD_CMD_POWER_OFF   8'h02
`define EPD_CMD_POWER_ON    8'h04
`define EPD_CMD_DEEP_SLEEP  8'h07
`define EPD_CMD_DATA_START  8'h10
`define EPD_CMD_DATA_STOP   8'h11
`define EPD_CMD_REFRESH     8'h12
`define EPD_CMD_AUTO_SEQ    8'h17
`define EPD_CMD_FRAME_RATE  8'h30
`define EPD_CMD_TEMP_READ   8'h40
`define EPD_CMD_TEMP_SEL    8'h41
`define EPD_CMD_POLARITY    8'h50

// ----------------------------------------------------------------
// Check codes and field positions
// ----------------------------------------------------------------
`define EPD_SLEEP_CHECK     8'ha5
`define EPD_AUTO_PLAIN      8'ha5
`define EPD_AUTO_SLEEP      8'ha7
`define EPD_FLAG_BIT        7
`define EPD_VCOM_BIT        0
`define EPD_DYN_BIT         3
`define EPD_SEN_BIT         7
`define EPD_POL_BIT         4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define EPD_RATE_RST        3'h2
`define EPD_POL_RST         1'b1

// ----------------------------------------------------------------
// Frame geometry and refresh shape
// ----------------------------------------------------------------
`define EPD_FRAME_BYTES     14'h2500
`define EPD_LUT_PHASES      2'h3
`define EPD_PIX_DIV         3'h3

// ----------------------------------------------------------------
// Timing: times in microseconds, clock in MHz
// ----------------------------------------------------------------
`define EPD_CLK_MHZ         250
`define EPD_PUP_TIME_US     1000
`define EPD_PDN_TIME_US     1000

// ----------------------------------------------------------------
// Software register byte addresses and interrupt bits
// ----------------------------------------------------------------
`define EPD_REG_STATUS      8'h00
`define EPD_REG_IRQ_STAT    8'h04
`define EPD_REG_IRQ_MASK    8'h08
`define EPD_REG_CONFIG      8'h0c
`define EPD_IRQ_REFRESH     0
`define EPD_IRQ_POWER_ON    1
`define EPD_IRQ_FRAME       2
`define EPD_IRQ_SLEEP       3
`define EPD_IRQ_IGNORED     4

`endif

// [core/epd_link_rx.v]
// Serial command/parameter link: byte receiver and read-back shifter
`timescale 1ns/10ps
module epd_link_rx (
  input  wire       clk_sys,
  input  wire       sys_rst,
  input  wire       sclk_pin,
  input  wire       csb_n_pin,
  input  wire       dc_pin,
  input  wire       sda_in,
  input  wire       tx_load,
  input  wire [7:0] tx_byte,
  input  wire       tx_en,
  output reg        byte_valid_q,
  output reg  [7:0] byte_q,
  output reg        byte_dc_q,
  output reg        sda_out_q,
  output reg        sda_oe_n_q
);

  // ----------------------------------------------------------------
  // Two-stage synchronisers: {sda, dc, csb_n, sclk}
  // ----------------------------------------------------------------
  reg [3:0] meta_q;     // First stage, read only by sync_q
  reg [3:0] sync_q;     // Second stage, safe to use
  reg       sclk_prev_q; // Delayed sclk for edge finding
  reg [2:0] bit_cnt_q;  // Bits taken in current byte
  reg [6:0] rx_sh_q;    // Incoming bits
  reg [7:0] tx_sh_q;    // Outgoing bits, MSB first

  wire sclk_s = sync_q[0];
  wire sel_s  = ~sync_q[1];
  wire rise   = sclk_s & ~sclk_prev_q & sel_s;
  wire fall   = ~sclk_s & sclk_prev_q & sel_s;

  // Synchronise the pins
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q      <= 4'h2;
      sync_q      <= 4'h2;
      sclk_prev_q <= 1'b0;
    end else begin
      meta_q      <= {sda_in, dc_pin, csb_n_pin, sclk_pin};
      sync_q      <= meta_q;
      sclk_prev_q <= sync_q[0];
    end
  end

  // Sample on rising edges; deselect drops a partial byte
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bit_cnt_q    <= 3'h0;
      rx_sh_q      <= 7'h00;
      byte_valid_q <= 1'b0;
      byte_q       <= 8'h00;
      byte_dc_q    <= 1'b0;
    end else begin
      byte_valid_q <= 1'b0;
      if (!sel_s) begin
        bit_cnt_q <= 3'h0;
      end else if (rise) begin
        bit_cnt_q <= bit_cnt_q + 3'h1;
        rx_sh_q   <= {rx_sh_q[5:0], sync_q[3]};
        if (bit_cnt_q == 3'h7) begin
          // Byte complete; the data/command level rides with it
          byte_valid_q <= 1'b1;
          byte_q       <= {rx_sh_q, sync_q[3]};
          byte_dc_q    <= sync_q[2];
        end
      end
    end
  end

  // Read-back shifter; no shift on the falling edge closing a byte,
  // so a byte loaded between bytes keeps its top bit for the next rise
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tx_sh_q    <= 8'h00;
      sda_out_q  <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end else begin
      if (tx_load) begin
        tx_sh_q <= tx_byte;
      end else if (fall && bit_cnt_q != 3'h0) begin
        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      end
      sda_out_q  <= tx_sh_q[7];
      sda_oe_n_q <= ~(tx_en & sel_s);
    end
  end

endmodule

// [tb/epd_chk.sv]
// Port checker for the panel driver command core
`timescale 1ns/10ps
module epd_chk (
  input wire        clk_sys,
  input wire        sys_rst,
  input wire        csb_n_pin,
  input wire        sda_oe_n,
  input wire        reg_rd,
  input wire [31:0] reg_rdata_q,
  input wire        busy_n_q,
  input wire        int_sensor_en_q,
  input wire [2:0]  frame_rate_select_q,
  input wire        dyn_frame_rate_q,
  input wire        src_strobe_q,
  input wire [1:0]  vcom_level_q,
  input wire        vcom_dc_q
);
  // ----------------------------------------------------------------
  // One clock domain, so one default clock and reset
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_strobe_busy: assert property (src_strobe_q |-> !busy_n_q) else $error("pixel strobe while ready");
  a_strobe_gap: assert property (src_strobe_q |=> !src_strobe_q [*3]) else $error("pixel strobe too soon");
  a_vcom_fixed: assert property (src_strobe_q && vcom_dc_q |-> vcom_level_q == 2'h1)
    else $error("fixed common level wrong");
  a_vcom_phase: assert property (src_strobe_q && !vcom_dc_q && !$past(src_strobe_q, 4) |-> vcom_level_q == 2'h0)
    else $error("first table level not zero");
  a_vcom_held: assert property (src_strobe_q ##4 src_strobe_q |-> vcom_dc_q == $past(vcom_dc_q, 4))
    else $error("common mode changed mid update");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0) else $error("read data outside slot");
  a_oe_idle: assert property (csb_n_pin [*8] |-> sda_oe_n) else $error("data pin driven while deselected");
  a_cfg_quiet: assert property (csb_n_pin [*8] |=>
    $stable({frame_rate_select_q, dyn_frame_rate_q, int_sensor_en_q})) else $error("setting moved without link");
endmodule
bind epd_cmd_core epd_chk chk (.clk_sys, .sys_rst, .csb_n_pin, .sda_oe_n, .reg_rd, .reg_rdata_q, .busy_n_q,
  .int_sensor_en_q, .frame_rate_select_q, .dyn_frame_rate_q, .src_strobe_q, .vcom_level_q, .vcom_dc_q);

// [tb/epd_host.sv]
// Host model on the serial command link
`timescale 1ns/10ps
module epd_host (
  input  wire clk_sys,
  input  wire sda_out,
  input  wire sda_oe_n,
  output reg  sclk_pin,
  output reg  csb_n_pin,
  output reg  dc_pin,
  output reg  sda_in
);
  reg [7:0] rd_q; // Last byte read back
  initial begin
    sclk_pin = 1'b0;
    csb_n_pin = 1'b1;
    dc_pin = 1'b0;
    sda_in = 1'b0;
  end
  // One byte, MSB first, 160 ns link clock idle low; data moves while low
  task xfer(input dc, input [7:0] b);
    integer i;
    begin
      @(posedge clk_sys) csb_n_pin <= 1'b0;
      dc_pin <= dc;
      for (i = 7; i >= 0; i = i - 1) begin
        sda_in <= b[i];
        repeat (20) @(posedge clk_sys);
        sclk_pin <= 1'b1;
        rd_q[i] <= sda_oe_n ? 1'b1 : sda_out;
        repeat (20) @(posedge clk_sys);
        sclk_pin <= 1'b0;
      end
      repeat (20) @(posedge clk_sys);
      // Released lines show the inverse so nothing stale passes for data
      csb_n_pin <= 1'b1;
      dc_pin <= ~dc;
      sda_in <= ~b[0];
    end
  endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench for the panel driver command core
`timescale 1ns/10ps
module testbench;
  reg         clk_sys = 1'b0;
  reg         sys_rst = 1'b1;
  reg  [7:0]  reg_addr = 8'h00;
  reg  [31:0] reg_wdata = 32'h0;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg  [9:0]  temp_int_raw = 10'h064;
  reg  [9:0]  temp_ext_raw = 10'h39d;
  wire        sclk_pin, csb_n_pin, dc_pin, sda_in, sda_out, sda_oe_n, busy_n_q, irq_q, int_sensor_en_q;
  wire        dyn_frame_rate_q, panel_power_q, src_strobe_q, vcom_dc_q;
  wire [31:0] reg_rdata_q;
  wire [2:0]  frame_rate_select_q;
  wire [1:0]  src_level_q, vcom_level_q;
  integer     fails = 0, check_count = 0, i, n;
  reg  [9:0]  t;
  reg  [2:0]  f;
  always #2 clk_sys = ~clk_sys;
  epd_cmd_core #(.PUP_CYC(20), .PDN_CYC(20)) dut (.clk_sys, .sys_rst, .sclk_pin, .csb_n_pin, .dc_pin, .sda_in,
    .sda_out, .sda_oe_n, .temp_int_raw, .temp_ext_raw, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
    .busy_n_q, .irq_q, .int_sensor_en_q, .frame_rate_select_q, .dyn_frame_rate_q, .panel_power_q, .src_level_q,
    .src_strobe_q, .vcom_level_q, .vcom_dc_q);
  epd_host host (.clk_sys, .sda_out, .sda_oe_n, .sclk_pin, .csb_n_pin, .dc_pin, .sda_in);
  task final_report;
    begin
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Bounded waits; running out ends the run
  task wait_busy(input v);
    begin
      for (n = 0; n < 2000 && busy_n_q !== v; n = n + 1) @(posedge clk_sys);
      if (busy_n_q !== v) begin
        chk(busy_n_q, v);
        final_report;
      end
    end
  endtask
  task rst;
    begin
      @(posedge clk_sys) sys_rst <= 1'b1;
      repeat (10) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_sys) reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys) reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] m, input [31:0] e);
    begin
      @(posedge clk_sys) reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys) reg_rd <= 1'b0;
      #1 chk(reg_rdata_q & m, e);
    end
  endtask
  task cmd(input [7:0] c, input [7:0] p);
    begin
      host.xfer(1'b0, c);
      host.xfer(1'b1, p);
    end
  endtask
  task t_power;
    begin
      fork
        host.xfer(1'b0, 8'h04);
        wait_busy(1'b0);
      join
      wait_busy(1'b1);
      chk(panel_power_q, 1'b1);
    end
  endtask
  task t_refresh(input m);
    begin
      t_power;
      wr(8'h08, 32'h10);
      fork
        cmd(8'h12, {7'h0, m});
        begin
          for (n = 0; n < 999 && src_strobe_q !== 1'b1; n = n + 1) @(posedge clk_sys);
          chk({src_strobe_q, src_level_q}, 3'h7);
          if (src_strobe_q !== 1'b1) final_report;
        end
      join
      chk(busy_n_q, 1'b0);
      chk(vcom_dc_q, m);
      f = frame_rate_select_q;
      cmd(8'h30, 8'h05);
      chk(frame_rate_select_q, f);
      repeat (3) @(posedge clk_sys);
      chk(irq_q, 1'b1);
      rd(8'h04, 32'h10, 32'h10);
      wr(8'h04, 32'h10);
      repeat (3) @(posedge clk_sys);
      chk(irq_q, 1'b0);
      rd(8'h20, 32'hffffffff, 32'h0);
      rst;
      $display("refresh mode %0d done", m);
    end
  endtask
  initial begin
    rst;
    chk({busy_n_q, int_sensor_en_q, irq_q, dyn_frame_rate_q, frame_rate_select_q}, 7'h62);
    for (i = 0; i < 16; i = i + 1) begin
      cmd(8'h30, i[7:0]);
      chk({dyn_frame_rate_q, frame_rate_select_q}, i[3:0]);
    end
    $display("frame rate done");
    cmd(8'h41, 8'h83);
    chk(int_sensor_en_q, 1'b0);
    t = temp_ext_raw + 10'd6;
    cmd(8'h40, 8'h00);
    chk(host.rd_q, t[9:2]);
    host.xfer(1'b1, 8'h00);
    chk(host.rd_q[7:6], t[1:0]);
    cmd(8'h41, 8'h00);
    chk(int_sensor_en_q, 1'b1);
    $display("temperature done");
    host.xfer(1'b0, 8'h10);
    host.xfer(1'b1, 8'hc6);
    cmd(8'h11, 8'h00);
    chk(host.rd_q[7], 1'b0);
    chk(busy_n_q, 1'b1);
    $display("data stop done");
    t_refresh(1'b0);
    t_refresh(1'b1);
    cmd(8'h17, 8'h00);
    chk(busy_n_q, 1'b1);
    cmd(8'h07, 8'h5a);
    chk(busy_n_q, 1'b1);
    cmd(8'h07, 8'ha5);
    chk(busy_n_q, 1'b0);
    cmd(8'h30, 8'h07);
    chk(frame_rate_select_q, 3'h2);
    rst;
    chk(busy_n_q, 1'b1);
    $display("sleep done");
    final_report;
  end
endmodule
